// ==== verilog/icr_config_regs.sv ====
// Purpose : apb register set steering a two-wire bus master engine
// Assumes : engine reports completion with a one-cycle done pulse
// Notes   : every apb access takes one wait state
`timescale 1ns/1ns
module icr_config_regs #(
  parameter int SCL_BASE  = icr_pkg::SCL_BASE,
  parameter int LEVEL_W   = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             engine_done,
  input  wire logic [LEVEL_W-1:0] fifo_level,
  output icr_pkg::icr_cfg_t     cfg,
  output icr_pkg::icr_cmd_t     cmd,
  output logic                  xfer_busy,
  output logic                  fast_plus,
  output logic [4:0]            sda_hold_cycles,
  output logic                  scl_tick,
  output logic                  fifo_level_irq
);

  // refuse settings the logic cannot serve
  if (SCL_BASE < 1 || SCL_BASE > 255) begin : g_chk_base
    $error("SCL_BASE must lie in 1..255");
  end
  if (LEVEL_W < 3 || LEVEL_W > 8) begin : g_chk_lvl
    $error("LEVEL_W must lie in 3..8");
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        busy_q;
  logic        access;
  logic        wr_en;
  logic        known;

  // decode a mapped word address; used by the error path, whose flag also blocks writes
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == icr_pkg::OFS_MODE)  || (a == icr_pkg::OFS_DIV)  ||
                (a == icr_pkg::OFS_HOLD)  || (a == icr_pkg::OFS_TADDR) ||
                (a == icr_pkg::OFS_TRIG)  || (a == icr_pkg::OFS_FRAME) ||
                (a == icr_pkg::OFS_CTRL);
  endfunction

  // settings writes, open only while idle
  function automatic logic cfg_wr(input logic       en,
                                  input logic       busy,
                                  input logic [7:0] a,
                                  input logic [7:0] want);
    cfg_wr = en && !busy && (a == want);
  endfunction

  // first access cycle prepares data, second one answers
  assign access = psel && penable && !pready_q;
  assign wr_en  = psel && penable && pready_q && pwrite && !pslverr_q;
  assign known  = is_mapped(paddr);
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // wait-state flag; clears after the answering edge
  // pready_q itself blocks a second answer in the very next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= access;
      pslverr_q <= access && !known;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // settings registers
  logic       dir_q;
  logic       aw_q;
  logic [7:0] div_q;
  logic [4:0] hold_q;
  logic [9:0] taddr_q;
  logic [2:0] rxtrg_q;
  logic [2:0] txtrg_q;
  logic [9:0] frame_q;
  logic       restore;
  logic       wr_mode;

  // restore shares the idle lock, so a restore never lands mid-transfer
  // lock while busy
  assign wr_mode = cfg_wr(wr_en, busy_q, paddr, icr_pkg::OFS_MODE);
  assign restore = wr_mode && pwdata[icr_pkg::MODE_RESTORE_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= 1'b0;
      aw_q  <= 1'b0;
    end else if (wr_mode) begin
      dir_q <= pwdata[icr_pkg::MODE_DIR_BIT];
      aw_q  <= pwdata[icr_pkg::MODE_AW_BIT];
    end
  end

  // divider; restore wins over a simultaneous field write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= icr_pkg::DIV_RST;
    end else if (restore) begin
      div_q <= icr_pkg::DIV_RST;
    end else if (cfg_wr(wr_en, busy_q, paddr, icr_pkg::OFS_DIV)) begin
      div_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= icr_pkg::HOLD_RST;
    end else if (restore) begin
      hold_q <= icr_pkg::HOLD_RST;
    end else if (cfg_wr(wr_en, busy_q, paddr, icr_pkg::OFS_HOLD)) begin
      hold_q <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taddr_q <= icr_pkg::TADDR_RST;
    end else if (restore) begin
      taddr_q <= icr_pkg::TADDR_RST;
    end else if (cfg_wr(wr_en, busy_q, paddr, icr_pkg::OFS_TADDR)) begin
      taddr_q <= pwdata[9:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxtrg_q <= icr_pkg::RXTRG_RST;
      txtrg_q <= icr_pkg::TXTRG_RST;
    end else if (restore) begin
      rxtrg_q <= icr_pkg::RXTRG_RST;
      txtrg_q <= icr_pkg::TXTRG_RST;
    end else if (cfg_wr(wr_en, busy_q, paddr, icr_pkg::OFS_TRIG)) begin
      rxtrg_q <= pwdata[icr_pkg::TRIG_RX_LSB +: 3];
      txtrg_q <= pwdata[icr_pkg::TRIG_TX_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q <= icr_pkg::FRAME_RST;
    end else if (restore) begin
      frame_q <= icr_pkg::FRAME_RST;
    end else if (cfg_wr(wr_en, busy_q, paddr, icr_pkg::OFS_FRAME)) begin
      frame_q <= pwdata[9:0];
    end
  end

  assign cfg = '{direction:             dir_q,
                 target_addr_width_sel: aw_q,
                 scl_divider:           div_q,
                 data_hold_count:       hold_q,
                 target_address:        taddr_q,
                 rx_level_trigger:      rxtrg_q,
                 tx_level_trigger:      txtrg_q,
                 frame_byte_total:      frame_q};

  //////////////////////////////////////////////////////////////////////////
  // go bit and engine commands
  logic flush_q;
  logic erst_q;
  logic start_q;
  logic go_wr;

  assign go_wr = wr_en && (paddr == icr_pkg::OFS_CTRL) &&
                 pwdata[icr_pkg::CTRL_GO_BIT];

  // go sets busy, done or engine reset clears it
  // a go while busy neither restarts nor disturbs
  // trade-off: mode is locked while busy, so no engine reset mid-transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (erst_q || (busy_q && engine_done)) begin
      busy_q <= 1'b0;
    end else if (go_wr && !busy_q) begin
      busy_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_q <= 1'b0;
      erst_q  <= 1'b0;
      start_q <= 1'b0;
    end else begin
      flush_q <= wr_mode && pwdata[icr_pkg::MODE_FLUSH_BIT];
      erst_q  <= wr_mode && pwdata[icr_pkg::MODE_ERST_BIT];
      start_q <= go_wr && !busy_q;
    end
  end

  assign cmd = '{queue_flush:  flush_q,
                 engine_reset: erst_q,
                 xfer_start:   start_q};
  assign xfer_busy = busy_q;

  //////////////////////////////////////////////////////////////////////////
  // readback
  // pulse and reserved bits read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (access) begin
      prdata_q <= 32'h0000_0000;
      unique case (paddr)
        icr_pkg::OFS_MODE: begin
          prdata_q[icr_pkg::MODE_DIR_BIT] <= dir_q;
          prdata_q[icr_pkg::MODE_AW_BIT]  <= aw_q;
        end
        icr_pkg::OFS_DIV:   prdata_q[7:0] <= div_q;
        icr_pkg::OFS_HOLD:  prdata_q[4:0] <= hold_q;
        icr_pkg::OFS_TADDR: prdata_q[9:0] <= taddr_q;
        icr_pkg::OFS_TRIG: begin
          prdata_q[icr_pkg::TRIG_RX_LSB +: 3] <= rxtrg_q;
          prdata_q[icr_pkg::TRIG_TX_LSB +: 3] <= txtrg_q;
        end
        icr_pkg::OFS_FRAME: prdata_q[9:0] <= frame_q;
        icr_pkg::OFS_CTRL:  prdata_q[icr_pkg::CTRL_GO_BIT] <= busy_q;
        default:            prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // scl rate enable and effective hold
  localparam logic [8:0] BASE9 = 9'(SCL_BASE);
  logic [8:0] scl_cnt_q;
  logic [8:0] scl_last;
  logic       scl_tick_q;
  logic       fmp_q;
  logic [4:0] hold_eff_q;

  // one tick every base plus divider cycles
  assign scl_last = BASE9 + {1'b0, div_q} - 9'd1;

  // counter only runs during a transfer so the phase starts fresh
  // the divider cannot move mid-transfer, so the spacing stays even
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_cnt_q  <= 9'd0;
      scl_tick_q <= 1'b0;
    end else if (!busy_q) begin
      scl_cnt_q  <= 9'd0;
      scl_tick_q <= 1'b0;
    end else begin
      scl_tick_q <= (scl_cnt_q == scl_last);
      scl_cnt_q  <= (scl_cnt_q == scl_last) ? 9'd0 : scl_cnt_q + 9'd1;
    end
  end

  // divider below the limit means fast-mode plus
  // zero count in slower modes falls back to 300 ns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmp_q      <= 1'b0;
      hold_eff_q <= icr_pkg::HOLD_RST;
    end else begin
      fmp_q      <= (div_q < icr_pkg::FMP_DIV_LIMIT);
      hold_eff_q <= (hold_q == 5'd0 && !(div_q < icr_pkg::FMP_DIV_LIMIT))
                    ? icr_pkg::HOLD_MIN_CYC : hold_q;
    end
  end

  assign scl_tick        = scl_tick_q;
  assign fast_plus       = fmp_q;
  assign sda_hold_cycles = hold_eff_q;

  //////////////////////////////////////////////////////////////////////////
  // fifo level request
  logic irq_q;

  // level equals trigger of the active direction
  // transmit trigger ignored while idle
  // receive compare runs while idle too, so software can poll it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else if (dir_q) begin
      irq_q <= (fifo_level == LEVEL_W'(rxtrg_q));
    end else begin
      irq_q <= busy_q && (fifo_level == LEVEL_W'(txtrg_q));
    end
  end

  assign fifo_level_irq = irq_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  // pulse checks rely on two answers never landing in adjacent cycles
  go_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    busy_q && engine_done |=> !busy_q && !start_q)
    else $error("go bit not cleared after done");

  go_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    busy_q && go_wr && !engine_done && !erst_q |=> busy_q && !start_q)
    else $error("go write disturbed a running transfer");

  cfg_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    busy_q && wr_en && (paddr != icr_pkg::OFS_CTRL) |=> $stable(cfg))
    else $error("settings changed while busy");

  restore_val_a: assert property (@(posedge pclk) disable iff (!presetn)
    restore |=> div_q == icr_pkg::DIV_RST && hold_q == icr_pkg::HOLD_RST &&
    taddr_q == icr_pkg::TADDR_RST && frame_q == icr_pkg::FRAME_RST &&
    rxtrg_q == icr_pkg::RXTRG_RST && txtrg_q == icr_pkg::TXTRG_RST)
    else $error("restore did not load defaults");

  pulse_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    flush_q || erst_q || start_q |=> !flush_q && !erst_q && !start_q)
    else $error("command pulse longer than one cycle");

  flush_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_mode && pwdata[icr_pkg::MODE_FLUSH_BIT] |=> flush_q ##1 !flush_q ||
    $past(wr_mode))
    else $error("flush bit gave no single pulse");

  hold_min_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_q == 5'd0 && div_q >= icr_pkg::FMP_DIV_LIMIT && $stable(hold_q) &&
    $stable(div_q) |=> hold_eff_q == icr_pkg::HOLD_MIN_CYC)
    else $error("zero hold count did not give minimum hold");

  tx_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !dir_q && !busy_q |=> !irq_q || $past(busy_q) == 1'b1 || $past(dir_q))
    else $error("transmit trigger used while idle");

  scl_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    scl_tick_q && busy_q && $stable(div_q) |-> scl_cnt_q == 9'd0)
    else $error("scl tick spacing wrong");

  rsv_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready_q && paddr == icr_pkg::OFS_DIV |-> prdata_q[31:8] == 24'h00_0000)
    else $error("reserved bits read nonzero");

  erst_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_mode && pwdata[icr_pkg::MODE_ERST_BIT] |=> erst_q && !busy_q)
    else $error("engine reset bit gave no pulse");

  go_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    go_wr && !busy_q && !erst_q |=> busy_q && start_q)
    else $error("go write did not start a transfer");

  rx_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    dir_q && fifo_level == LEVEL_W'(rxtrg_q) |=> irq_q)
    else $error("receive level request missing");

  tx_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    !dir_q && busy_q && fifo_level == LEVEL_W'(txtrg_q) |=> irq_q)
    else $error("transmit level request missing");

endmodule

// ==== pkg/icr_pkg.sv ====
// Purpose : constants and carriers for the two-wire master config registers
// Assumes : 32-bit apb, one aligned word per register, pclk at 50 MHz
// Notes   : offsets are byte addresses
//
// Overview of operation
// - direction bit: 0 transmit, 1 receive
// - width select: 0 seven-bit, 1 ten-bit address
// - mode bit 2 pulses a queue flush
// - mode bit 3 restores settings registers
// - mode bit 4 pulses bus engine reset
// - go bit starts transfer, self-clears when done
// - go write ignored while transfer runs
// - divider bits 7:0, reset 0xF4
// - scl rate is clock over 27 plus divider
// - hold count bits 4:0, reset 0x09
// - zero hold count still gives 300 ns below fast-mode plus; in fast-mode plus it gives zero hold
// - target address bits 9:0, reset 0x2A
// - receive trigger bits 10:8, reset 0x7
// - transmit trigger bits 2:0, reset 0x1
// - request when level equals active trigger
// - transmit trigger used only during transfer
// - frame byte total bits 9:0, reset 0
// - configuration read-only while transfer runs
package icr_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_DIV    = 8'h04;
  localparam logic [7:0] OFS_HOLD   = 8'h08;
  localparam logic [7:0] OFS_TADDR  = 8'h0C;
  localparam logic [7:0] OFS_TRIG   = 8'h10;
  localparam logic [7:0] OFS_FRAME  = 8'h14;
  localparam logic [7:0] OFS_CTRL   = 8'h20;

  // mode, control and trigger register fields
  localparam int MODE_DIR_BIT     = 0;
  localparam int MODE_AW_BIT      = 1;
  localparam int MODE_FLUSH_BIT   = 2;
  localparam int MODE_RESTORE_BIT = 3;
  localparam int MODE_ERST_BIT    = 4;
  localparam int CTRL_GO_BIT      = 0;
  localparam int TRIG_RX_LSB      = 8;
  localparam int TRIG_TX_LSB      = 0;

  // reset values
  localparam logic [7:0] DIV_RST   = 8'hF4;
  localparam logic [4:0] HOLD_RST  = 5'h09;
  localparam logic [9:0] TADDR_RST = 10'h02A;
  localparam logic [2:0] RXTRG_RST = 3'h7;
  localparam logic [2:0] TXTRG_RST = 3'h1;
  localparam logic [9:0] FRAME_RST = 10'h000;

  // scl rate: base added to divider; above 400 kHz when divider below this
  localparam int         SCL_BASE      = 27;
  localparam logic [7:0] FMP_DIV_LIMIT = 8'h29;

  // least sda hold, rounded up to whole clock cycles
  localparam int CLK_PERIOD_NS = 20;
  localparam int HOLD_MIN_NS   = 300;
  localparam int HOLD_MIN_CYC_I =
    (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] HOLD_MIN_CYC = HOLD_MIN_CYC_I[4:0];

  // settings seen by the bus engine
  typedef struct packed {
    logic       direction;
    logic       target_addr_width_sel;
    logic [7:0] scl_divider;
    logic [4:0] data_hold_count;
    logic [9:0] target_address;
    logic [2:0] rx_level_trigger;
    logic [2:0] tx_level_trigger;
    logic [9:0] frame_byte_total;
  } icr_cfg_t;

  // one-cycle commands to the bus engine
  typedef struct packed {
    logic queue_flush;
    logic engine_reset;
    logic xfer_start;
  } icr_cmd_t;

endpackage

// ==== testbench/icr_engine_model.sv ====
// Purpose : behavioural bus engine standing behind the config registers
// Assumes : done follows start after a bench-chosen number of cycles
// Notes   : queue level follows the bench value, flush empties it
`timescale 1ns/1ns
module icr_engine_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  icr_pkg::icr_cmd_t cmd,
  input  wire logic [7:0]  dly,
  input  wire logic [3:0]  lvl_set,
  output logic             engine_done,
  output logic [3:0]       fifo_level
);
  logic       run_q;
  logic [7:0] cnt_q;
  logic [3:0] lvl_q;

  ////////////////////////////////////////////////////////////////////////
  // transfer timing: a slow dly shows the go bit standing for long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q       <= 1'b0;
      cnt_q       <= 8'h00;
      engine_done <= 1'b0;
    end else begin
      engine_done <= 1'b0;
      if (cmd.engine_reset) begin
        run_q <= 1'b0;
      end else if (cmd.xfer_start) begin
        run_q <= 1'b1;
        cnt_q <= 8'h00;
      end else if (run_q && cnt_q == dly) begin
        engine_done <= 1'b1;
        run_q       <= 1'b0;
      end else if (run_q) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flush empties queue; the level then moves only with new bench data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_level <= 4'h0;
      lvl_q      <= 4'h0;
    end else begin
      lvl_q <= lvl_set;
      if (cmd.queue_flush) begin
        fifo_level <= 4'h0;
      end else if (lvl_set != lvl_q) begin
        fifo_level <= lvl_set;
      end
    end
  end
endmodule

// ==== testbench/testbench.sv ====
// Purpose : self-checking bench for the two-wire master config registers
// Assumes : apb answers in its own time, bench waits for pready
// Notes   : random data from a fixed seed, corner cases written by hand
`timescale 1ns/1ns
module testbench;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              engine_done;
  logic [3:0]        fifo_level;
  icr_pkg::icr_cfg_t cfg;
  icr_pkg::icr_cmd_t cmd;
  logic              xfer_busy;
  logic              fast_plus;
  logic [4:0]        sda_hold_cycles;
  logic              scl_tick;
  logic              fifo_level_irq;
  logic [7:0]        dly;
  logic [3:0]        lvl_set;
  logic [31:0]       rd;
  logic              err;
  int                error_cnt;
  int                cmp_count;
  int                seed;
  int                npulse [3];
  int                cyc;
  int                tlast;
  int                tgap;
  logic [31:0]       msk [6] = '{32'h0000_0003, 32'h0000_00FF,
    32'h0000_001F, 32'h0000_03FF, 32'h0000_0707, 32'h0000_03FF};
  logic [31:0]       dft [6] = '{32'h0000_0000, 32'h0000_00F4,
    32'h0000_0009, 32'h0000_002A, 32'h0000_0701, 32'h0000_0000};

  icr_config_regs icr_config_regs_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .engine_done(engine_done), .fifo_level(fifo_level), .cfg(cfg),
    .cmd(cmd), .xfer_busy(xfer_busy), .fast_plus(fast_plus),
    .sda_hold_cycles(sda_hold_cycles), .scl_tick(scl_tick),
    .fifo_level_irq(fifo_level_irq));
  icr_engine_model icr_engine_model_inst (.pclk(pclk), .presetn(presetn),
    .cmd(cmd), .dly(dly), .lvl_set(lvl_set), .engine_done(engine_done),
    .fifo_level(fifo_level));

  ////////////////////////////////////////////////////////////////////////
  // clock, and counters of pulses and tick spacing
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    npulse[0] += int'(cmd.queue_flush);
    npulse[1] += int'(cmd.engine_reset);
    npulse[2] += int'(cmd.xfer_start);
    if (scl_tick === 1'b1) begin
      tgap  = cyc - tlast;
      tlast = cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // verdict and watchdog
  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      error_cnt++;
    end
  endtask

  // apb transfer: request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected value after a write: only the documented fields stick
  function automatic logic [31:0] keep(input int i, input logic [31:0] d);
    return d & msk[i];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] d;
    logic [31:0] m;
    int          p0;
    seed = 32'h799d_b895;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    dly = 8'h96;
    lvl_set = 4'h1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, dft[i]); // reset value read
    end
    apb(1'b0, 8'h18, 32'hFFFF_FFFF);
    chk({err, rd[30:0]}, 32'h8000_0000); // unmapped refused
    // random fields, reserved bits dropped, pulse bits read zero
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      if (i == 0) begin
        m = d;
      end
      apb(1'b1, 8'(4 * i), d);
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, keep(i, d)); // reserved read zero
    end
    chk(32'(cfg.direction), 32'(m[0])); // direction bit seen
    chk(32'(cfg.target_addr_width_sel), 32'(m[1])); // width bit seen
    apb(1'b1, 8'h00, 32'h0000_0008);
    for (int i = 1; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, dft[i]); // restore defaults
    end
    d = 32'({icr_pkg::DIV_RST, icr_pkg::HOLD_RST, icr_pkg::TADDR_RST});
    chk(32'(cfg[38:16]), d); // restored settings seen by engine
    d = 32'({icr_pkg::RXTRG_RST, icr_pkg::TXTRG_RST, icr_pkg::FRAME_RST});
    chk(32'(cfg[15:0]), d); // restored triggers and frame total
    lvl_set <= 4'h2;
    for (int b = 0; b < 2; b++) begin
      p0 = npulse[b];
      apb(1'b1, 8'h00, b ? 32'h0000_0010 : 32'h0000_0004);
      repeat (3) @(posedge pclk);
      chk(32'(npulse[b] - p0), 32'h1); // single cycle pulse
    end
    chk(32'(fifo_level), 32'h0); // flush empties queue
    lvl_set <= 4'h1;
    apb(1'b1, 8'h00, 32'h0000_0002);
    @(posedge pclk);
    chk(32'(cfg.target_addr_width_sel), 32'h1); // ten-bit select
    // transfer: fast divider, zero hold, second go and writes ignored
    d = 32'h0000_0005 + ($random(seed) & 32'h0000_000F);
    apb(1'b1, 8'h04, d);
    apb(1'b1, 8'h08, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'({fast_plus, sda_hold_cycles}), 32'h20); // fast plus hold
    p0 = npulse[2];
    apb(1'b1, 8'h20, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk(32'(xfer_busy), 32'h1); // go starts transfer
    chk(32'(fifo_level_irq), 32'h1); // tx trigger during transfer
    apb(1'b1, 8'h20, 32'h0000_0001);
    chk(32'(npulse[2] - p0), 32'h1); // go ignored while busy
    apb(1'b1, 8'h04, 32'h0000_00AA);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, d); // settings locked while busy
    repeat (110) @(posedge pclk);
    chk(32'(tgap), 32'(27) + d); // scl tick spacing
    for (int n = 0; n < 400 && xfer_busy === 1'b1; n++) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0); // go clears when done
    chk(32'(fifo_level_irq), 32'h0); // tx trigger ignored when idle
    // receive direction, trigger compare on equal level only
    apb(1'b1, 8'h00, 32'h0000_0001);
    apb(1'b1, 8'h10, 32'h0000_0301);
    lvl_set <= 4'h3;
    repeat (3) @(posedge pclk);
    chk(32'(fifo_level_irq), 32'h1); // level equals rx trigger
    lvl_set <= 4'h4;
    repeat (3) @(posedge pclk);
    chk(32'(fifo_level_irq), 32'h0); // rx trigger compare
    // slow divider, zero hold count gives the least hold
    apb(1'b1, 8'h04, 32'h0000_006D);
    apb(1'b1, 8'h08, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(sda_hold_cycles), 32'(icr_pkg::HOLD_MIN_CYC)); // min hold
    apb(1'b1, 8'h08, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    chk(32'(sda_hold_cycles), 32'h7); // hold count used
    finish_test();
  end
endmodule
